// file: core/srsup_map.svh
// constants and the behaviour notes for the setting range supervisor
// Notes on behaviour
// - running: reject bad refreshed word, keep old
// - running error: error indicator on, run on
// - store lowest faulty word offset, four hex
// - corrected refreshed word adopted without restart
// - after correction offset zero or next fault
// - after live correction indicators stay until restart
// - start with bad refreshed word: no run
// - start all valid: run on, error off
// - bad start-up word while running: keep originals
// - start-up area: offset zero unless faulty
// - start with bad start-up word: no run
// - restart pulse reruns start-up checks
`ifndef SRSUP_MAP_SVH
`define SRSUP_MAP_SVH
`define SRSUP_NUM_LIVE      8
`define SRSUP_NUM_INIT      8
`define SRSUP_INIT_BASE     16'h0008
`define SRSUP_OFFSET_NONE   16'h0000
`define SRSUP_WORD_RESET    16'h0000
`define SRSUP_LIMIT_MIN     16'h0000
`define SRSUP_LIMIT_MAX     16'h7fff
`endif

// file: core/srsup_pkg.sv
// types for the setting range supervisor
`default_nettype none
package srsup_pkg;
	typedef enum logic [1:0] {
		SRSUP_BOOT,
		SRSUP_RUN,
		SRSUP_HALT
	} srsup_state_t;
endpackage
`default_nettype wire

// file: core/srsup_scan.sv
// range check of a word array, lowest failing index first
`include "srsup_map.svh"
`default_nettype none
module srsup_scan #(
	parameter int NUM = 8
) (
	input  wire logic [NUM*16-1:0] words,     // flattened words, index 0 lowest
	input  wire logic [NUM*16-1:0] lo_limits, // per-word least value
	input  wire logic [NUM*16-1:0] hi_limits, // per-word greatest value
	output logic      [NUM-1:0]    bad,       // per-word out of range
	output logic                   any_bad,   // some word out of range
	output logic      [15:0]       low_index  // smallest failing index
);
	initial begin
		if (NUM < 1 || NUM > 65535) $error("srsup_scan: NUM out of range");
	end
	always_comb begin
		bad = '0;
		any_bad = 1'b0;
		low_index = `SRSUP_OFFSET_NONE;
		// downward walk so the smallest failing index is the last to win
		for (int i = NUM - 1; i >= 0; i--) begin
			if (words[i*16 +: 16] < lo_limits[i*16 +: 16] ||
			    words[i*16 +: 16] > hi_limits[i*16 +: 16]) begin
				bad[i] = 1'b1;
				any_bad = 1'b1;
				low_index = 16'(i);
			end
		end
	end
endmodule
`default_nettype wire

// file: core/srsup_top.sv
// setting range supervisor: checks host-written settings, gates start-up
`include "srsup_map.svh"
`default_nettype none
module srsup_top #(
	parameter int NUM_LIVE = `SRSUP_NUM_LIVE,
	parameter int NUM_INIT = `SRSUP_NUM_INIT
) (
	input  wire logic                  mclk,              // 200 MHz clock
	input  wire logic                  rst,               // sync reset, high = power-on
	input  wire logic                  restart_bit,       // host restart bit, async
	input  wire logic [NUM_LIVE*16-1:0] live_words,       // refreshed area from host
	input  wire logic [NUM_INIT*16-1:0] init_words,       // start-up area from host
	input  wire logic [NUM_LIVE*16-1:0] live_lo,          // refreshed area least values
	input  wire logic [NUM_LIVE*16-1:0] live_hi,          // refreshed area greatest values
	input  wire logic [NUM_INIT*16-1:0] init_lo,          // start-up area least values
	input  wire logic [NUM_INIT*16-1:0] init_hi,          // start-up area greatest values
	output logic                       run_indicator,     // unit running
	output logic                       config_error_indicator, // setting error seen
	output logic      [15:0]           error_offset,      // lowest faulty word offset
	output logic      [NUM_LIVE*16-1:0] live_active,      // accepted refreshed settings
	output logic      [NUM_INIT*16-1:0] init_active       // settings loaded at start
);
	import srsup_pkg::*;

	initial begin
		if (NUM_LIVE < 1 || NUM_LIVE > int'(`SRSUP_INIT_BASE))
			$error("srsup_top: NUM_LIVE must fit below the start-up area base");
		if (NUM_INIT < 1 || NUM_INIT > 4096)
			$error("srsup_top: NUM_INIT out of range");
	end

	typedef struct packed {
		srsup_state_t            state;
		logic                    restart_meta;
		logic                    restart_sync;
		logic                    restart_prev;
		logic                    restart_armed;
		logic                    run;
		logic                    err;
		logic [15:0]             offset;
		logic [NUM_LIVE*16-1:0]  live;
		logic [NUM_INIT*16-1:0]  init;
	} srsup_regs_t;

	srsup_regs_t r;
	srsup_regs_t next_r;

	logic [NUM_LIVE-1:0] live_bad;
	logic                live_any;
	logic [15:0]         live_low;
	logic [NUM_INIT-1:0] init_bad;
	logic                init_any;
	logic [15:0]         init_low;
	logic                restart_fall;

	srsup_scan #(.NUM(NUM_LIVE)) u_live (
		.words     (live_words),
		.lo_limits (live_lo),
		.hi_limits (live_hi),
		.bad       (live_bad),
		.any_bad   (live_any),
		.low_index (live_low)
	);

	srsup_scan #(.NUM(NUM_INIT)) u_init (
		.words     (init_words),
		.lo_limits (init_lo),
		.hi_limits (init_hi),
		.bad       (init_bad),
		.any_bad   (init_any),
		.low_index (init_low)
	);

	// smallest faulty offset over both areas; live area sits lower
	function automatic logic [15:0] lowest_offset(input logic la, input logic [15:0] lo_l,
	                                              input logic ia, input logic [15:0] lo_i);
		logic [15:0] v;
		v = `SRSUP_OFFSET_NONE;
		if (ia)
			v = 16'(`SRSUP_INIT_BASE + lo_i);
		if (la)
			v = lo_l;
		return v;
	endfunction

	// on then off: act on the falling edge of the synchronised bit
	assign restart_fall = r.restart_prev & ~r.restart_sync;

	always_comb begin
		next_r = r;
		next_r.restart_meta = restart_bit;
		next_r.restart_sync = r.restart_meta;
		next_r.restart_prev = r.restart_sync;
		if (r.restart_sync)
			next_r.restart_armed = 1'b1;
		unique case (r.state)
			SRSUP_BOOT: begin
				// full start-up check over every word of both areas
				next_r.offset = lowest_offset(live_any, live_low, init_any, init_low);
				if (live_any || init_any) begin
					next_r.state = SRSUP_HALT;
					next_r.run = 1'b0;
					next_r.err = 1'b1;
				end else begin
					next_r.state = SRSUP_RUN;
					next_r.run = 1'b1;
					next_r.err = 1'b0;
					next_r.live = live_words;
					next_r.init = init_words;
				end
			end
			SRSUP_RUN: begin
				next_r.run = 1'b1;
				// per word: a bad word is rejected, a good one adopted live
				for (int i = 0; i < NUM_LIVE; i++) begin
					if (!live_bad[i])
						next_r.live[i*16 +: 16] = live_words[i*16 +: 16];
				end
				// start-up settings stay as loaded for the whole run
				if (live_any || init_any)
					next_r.err = 1'b1;
				// error stays lit after correction until a restart
				next_r.offset = lowest_offset(live_any, live_low, init_any, init_low);
			end
			SRSUP_HALT: begin
				next_r.run = 1'b0;
				next_r.err = 1'b1;
				// offset tracks edits so the host sees what remains
				next_r.offset = lowest_offset(live_any, live_low, init_any, init_low);
			end
		endcase
		if (restart_fall && r.restart_armed) begin
			next_r.state = SRSUP_BOOT;
			next_r.run = 1'b0;
			next_r.restart_armed = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			r.state <= SRSUP_BOOT;
			r.restart_meta <= 1'b0;
			r.restart_sync <= 1'b0;
			r.restart_prev <= 1'b0;
			r.restart_armed <= 1'b0;
			r.run <= 1'b0;
			r.err <= 1'b0;
			r.offset <= `SRSUP_OFFSET_NONE;
			r.live <= {NUM_LIVE{`SRSUP_WORD_RESET}};
			r.init <= {NUM_INIT{`SRSUP_WORD_RESET}};
		end else begin
			r <= next_r;
		end
	end

	assign run_indicator = r.run;
	assign config_error_indicator = r.err;
	assign error_offset = r.offset;
	assign live_active = r.live;
	assign init_active = r.init;
endmodule
`default_nettype wire

// file: test/srsup_host.sv
// host model: range limits and restart bit
`default_nettype none
module srsup_host (
	input  wire logic         mclk,        // clock
	input  wire logic         req,         // ask for a restart
	output logic              restart_bit, // restart bit to unit
	output logic [127:0]      lim_lo,      // least values
	output logic [127:0]      lim_hi       // greatest values
);
	timeunit 1ns;
	timeprecision 1ps;
	assign lim_lo = {8{16'h0010}};
	assign lim_hi = {8{16'h7fff}};
	initial restart_bit = 1'b0;
	// act on the rise of req only: a level test at the same negedge
	// that the bench moves req on races and can pulse twice
	always @(posedge req) begin
		@(negedge mclk);
		restart_bit <= 1'b1;
		repeat (3) @(negedge mclk);
		restart_bit <= 1'b0;
	end
endmodule
`default_nettype wire

// file: test/srsup_sva.sv
// assertions on the supervisor ports
`default_nettype none
module srsup_sva #(parameter int NUM_LIVE = 8, parameter int NUM_INIT = 8) (
	input wire logic mclk, rst, restart_bit, run_indicator, config_error_indicator,
	input wire logic [15:0] error_offset,
	input wire logic [NUM_LIVE*16-1:0] live_words, live_lo, live_hi, live_active,
	input wire logic [NUM_INIT*16-1:0] init_active
);
	logic b0, b1;
	assign b0 = live_words[15:0] < live_lo[15:0] || live_words[15:0] > live_hi[15:0];
	assign b1 = live_words[31:16] < live_lo[31:16] || live_words[31:16] > live_hi[31:16];
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_keep; run_indicator && b0 |=> !run_indicator || $stable(live_active[15:0]); endproperty
	a_keep: assert property (p_keep) else $error("bad word adopted");
	property p_take; run_indicator && !b0 |=> !run_indicator ||
		live_active[15:0] == $past(live_words[15:0]); endproperty
	a_take: assert property (p_take) else $error("good word not adopted");
	property p_off0; run_indicator && b0 |=> !run_indicator || error_offset == 16'h0000; endproperty
	a_off0: assert property (p_off0) else $error("offset of word 0 wrong");
	property p_off1; run_indicator && !b0 && b1 |=> !run_indicator || error_offset == 16'h0001;
	endproperty
	a_off1: assert property (p_off1) else $error("lowest offset wrong");
	property p_hold; run_indicator && config_error_indicator |=> !run_indicator ||
		config_error_indicator; endproperty
	a_hold: assert property (p_hold) else $error("error cleared while running");
	property p_start; $rose(run_indicator) |-> !config_error_indicator &&
		error_offset == 16'h0000; endproperty
	a_start: assert property (p_start) else $error("start with error shown");
	property p_init; $past(run_indicator) && run_indicator |-> $stable(init_active); endproperty
	a_init: assert property (p_init) else $error("start-up settings reloaded");
	property p_rst; restart_bit [*3] ##1 !restart_bit |-> ##[1:8] !run_indicator; endproperty
	a_rst: assert property (p_rst) else $error("restart ignored");
	property p_halt; (!run_indicator && config_error_indicator && !restart_bit) [*8] |=>
		!run_indicator; endproperty
	a_halt: assert property (p_halt) else $error("halted unit started");
	cover property (run_indicator && b0);
	cover property ($rose(run_indicator));
	cover property ($fell(restart_bit));
endmodule
bind srsup_top srsup_sva #(.NUM_LIVE(NUM_LIVE), .NUM_INIT(NUM_INIT)) u_sva (.*);
`default_nettype wire

// file: test/test_setting_range_error_supervisor.sv
// self-checking bench for the setting range supervisor
`default_nettype none
module test_setting_range_error_supervisor;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, rst = 1, req = 0, restart_bit, run, err, m_run, m_err;
	logic [15:0] off, m_off;
	logic [7:0][15:0] lw, iw, ma, mi;
	logic [127:0] lo, hi, la, ia;
	int num_errors = 0, n_tests = 0, lb;
	always #2.5 mclk = ~mclk;
	srsup_host u_host (.mclk(mclk), .req(req), .restart_bit(restart_bit),
		.lim_lo(lo), .lim_hi(hi));
	srsup_top u_dut (.mclk(mclk), .rst(rst), .restart_bit(restart_bit), .live_words(lw),
		.init_words(iw), .live_lo(lo), .live_hi(hi), .init_lo(lo), .init_hi(hi),
		.run_indicator(run), .config_error_indicator(err), .error_offset(off),
		.live_active(la), .init_active(ia));
	function automatic bit bad(logic [15:0] v);
		return v < 16'h0010 || v[15];
	endfunction
	function automatic logic [15:0] good();
		return 16'h0010 + 16'($urandom % 32'h7ff0);
	endfunction
	task automatic chk(string s, logic [127:0] seen, logic [127:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task automatic look();
		lb = -1;
		for (int i = 15; i >= 0; i--)
			if (bad(i < 8 ? lw[i] : iw[i-8])) lb = i;
		m_off = lb < 0 ? 16'h0000 : 16'(lb);
		if (m_run) m_err = m_err | (lb >= 0);
		for (int i = 0; i < 8; i++)
			if (m_run && !bad(lw[i])) ma[i] = lw[i];
		repeat (3) @(negedge mclk);
		chk("run", run, m_run);
		chk("error", err, m_err);
		chk("offset", off, m_off);
		if (m_run) chk("live", la, ma);
		if (m_run) chk("init", ia, mi);
		$display("step done, errors %0d", num_errors);
	endtask
	task automatic put(bit s, int i, logic [15:0] v);
		@(negedge mclk);
		if (s) iw[i] = v;
		else lw[i] = v;
		look();
	endtask
	task automatic boot(bit pw);
		@(negedge mclk);
		if (pw) rst = 1;
		else req = 1;
		repeat (4) @(negedge mclk);
		rst = 0;
		req = 0;
		repeat (12) @(negedge mclk);
		m_run = 1;
		for (int i = 0; i < 8; i++) m_run = m_run & !bad(lw[i]) & !bad(iw[i]);
		m_err = !m_run;
		if (m_run) ma = lw;
		if (m_run) mi = iw;
		look();
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		void'($urandom(30021));
		for (int i = 0; i < 8; i++) begin
			lw[i] = good();
			iw[i] = good();
		end
		boot(1);
		put(0, 3, 16'h8000 | 16'($urandom));
		put(0, 1, 16'h000f);
		put(0, 1, good());
		put(0, 3, good());
		put(1, 2, 16'h000f);
		boot(0);
		put(1, 2, good());
		put(0, 5, 16'hffff);
		boot(0);
		put(0, 5, good());
		boot(0);
		put(0, 0, 16'h0000);
		boot(1);
		end_of_test();
	end
endmodule
`default_nettype wire
